// File: logic/mmi2c_ctrl.sv
/*
  Multi-master two-wire serial bus interface: APB register slave, clock
  prescaler, master clock generator with start and stop, shared byte
  engine for master and slave, arbitration and address-match status.
  Assumes bus pins are already synchronous to clk_sys and that the
  pad resolves each open-drain pin from its active-low output enable.
*/
`timescale 1ns/1ns
`default_nettype none
module mmi2c_ctrl
  import mmi2c_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe_n,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe_n,
  output var  logic        irq
);

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  logic        ack_en;
  logic        src_slow;
  logic        int_en;
  logic        pending;
  logic [3:0]  prescale;
  logic [1:0]  mode;
  logic        busy;
  logic        ser_en;
  logic        arb_lost;
  logic        addr_match;
  logic        gen_call;
  logic        last_bit;
  logic [7:0]  own_addr;
  logic [7:0]  shift_data;
  logic        data_wait;
  logic        stop_req;
  logic        slave_sel;
  logic        addr_phase;
  logic        first_fall;
  logic [3:0]  bit_cnt;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  div_cnt;
  logic [3:0]  ps_cnt;
  mmi2c_cg_t   cg_state;
  logic        cg_scl_low;
  logic        cg_sda_low;

  logic        wr_acc;
  logic        rd_acc;
  logic        scl_rise;
  logic        scl_fall;
  logic        bit_fall;
  logic        start_det;
  logic        stop_det;
  logic        mastering;
  logic        engaged;
  logic        hold;
  logic        tx_role;
  logic        src_tick;
  logic        half_tick;
  logic        arb_evt;
  logic        byte_done;
  logic        addr_ok;
  logic        gc_ok;
  logic        master_go;
  logic        eng_sda_low;
  logic        next_scl_low;
  logic        next_sda_low;
  logic [31:0] next_prdata;

  assign wr_acc    = psel & penable & pready & pwrite;
  assign rd_acc    = psel & penable & pready & ~pwrite;
  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  // The clock fall that closes a start carries no bit and must not count
  assign bit_fall  = scl_fall & ~first_fall;
  assign start_det = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;
  assign mastering = (cg_state != MMI2C_CG_IDLE);
  assign engaged   = ser_en & (mastering | slave_sel);
  assign hold      = pending | data_wait;
  // Address byte always goes out from the master, whatever its mode says
  assign tx_role   = mastering ? (addr_phase | mode[0]) : (~addr_phase & mode[0]);
  assign byte_done = bit_fall & (bit_cnt == ACK_SLOT) & engaged;
  assign addr_ok   = (shift_data[7:1] == own_addr[7:1]);
  assign gc_ok     = (shift_data[7:1] == GENERAL_CALL);
  // A lost bit is a one we released that the bus reads as zero
  assign arb_evt   = mastering & tx_role & scl_rise & (bit_cnt < ACK_SLOT)
                   & shift_data[7] & ~sda_in;
  assign master_go = wr_acc & hit(paddr, ADDR_CTRL_STATUS) & pwdata[ST_BUSY]
                   & pwdata[7] & pwdata[ST_ENABLE] & ~mastering;

  // Prescaler: source divide 16 or 512, then prescale+1, in half periods
  assign src_tick  = (div_cnt == (src_slow ? HALF_SLOW_M1 : HALF_FAST_M1));
  assign half_tick = src_tick & (ps_cnt == prescale);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 8'h00;
      ps_cnt  <= 4'h0;
    end else if (!mastering || src_tick) begin
      div_cnt <= 8'h00;
      if (!mastering || half_tick) begin
        ps_cnt <= 4'h0;
      end else begin
        ps_cnt <= ps_cnt + 4'h1;
      end
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // APB answers in the first access cycle; unmapped addresses get pslverr
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= DATA_ZERO;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit(paddr, ADDR_BUS_CONTROL)
               | hit(paddr, ADDR_CTRL_STATUS) | hit(paddr, ADDR_OWN_ADDRESS)
               | hit(paddr, ADDR_SHIFT_DATA));
      prdata  <= next_prdata;
    end
  end

  always_comb begin
    next_prdata = DATA_ZERO;
    if (psel && !penable) begin
      if (hit(paddr, ADDR_BUS_CONTROL)) begin
        next_prdata[7:0] = {ack_en, src_slow, int_en, pending, prescale};
      end else if (hit(paddr, ADDR_CTRL_STATUS)) begin
        next_prdata[7:0] = {mode, busy, ser_en, arb_lost, addr_match,
                            gen_call, last_bit};
      end else if (hit(paddr, ADDR_OWN_ADDRESS)) begin
        next_prdata[7:0] = {own_addr[7:1], 1'b0};
      end else if (hit(paddr, ADDR_SHIFT_DATA)) begin
        next_prdata[7:0] = shift_data;
      end else begin
        next_prdata = DATA_ZERO;
      end
    end
  end

  // Control register; prescale has no reset value of its own
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_en   <= 1'b0;
      src_slow <= 1'b0;
      int_en   <= 1'b0;
    end else if (wr_acc && hit(paddr, ADDR_BUS_CONTROL)) begin
      ack_en   <= pwdata[BC_ACK_EN];
      src_slow <= pwdata[BC_SRC_SEL];
      int_en   <= pwdata[BC_INT_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_acc && hit(paddr, ADDR_BUS_CONTROL)) begin
      prescale <= pwdata[3:0];
    end
  end

  // Pending: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
    end else if (byte_done || arb_evt) begin
      pending <= 1'b1;
    end else if (wr_acc && hit(paddr, ADDR_BUS_CONTROL) && !pwdata[BC_PENDING]) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= pending & int_en;
    end
  end

  // Stall after each byte until software touches the data register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_wait <= 1'b0;
    end else if (byte_done) begin
      data_wait <= 1'b1;
    end else if ((wr_acc || rd_acc) && hit(paddr, ADDR_SHIFT_DATA)) begin
      data_wait <= 1'b0;
    end else if (!ser_en) begin
      data_wait <= 1'b0;
    end
  end

  // Mode and enable; hardware moves the mode on address or lost arbitration
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode   <= MODE_SLAVE_RX;
      ser_en <= 1'b0;
    end else if (arb_evt) begin
      mode <= MODE_SLAVE_RX;
    end else if (byte_done && addr_phase && !mastering && addr_ok) begin
      mode <= shift_data[0] ? MODE_SLAVE_TX : MODE_SLAVE_RX;
    end else if (wr_acc && hit(paddr, ADDR_CTRL_STATUS)) begin
      mode   <= pwdata[7:6];
      ser_en <= pwdata[ST_ENABLE];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stop_req <= 1'b0;
    end else if (!mastering) begin
      stop_req <= 1'b0;
    end else if (wr_acc && hit(paddr, ADDR_CTRL_STATUS) && !pwdata[ST_BUSY]) begin
      stop_req <= 1'b1;
    end
  end

  // Own address: no reset value, frozen while serial is enabled
  always_ff @(posedge clk_sys) begin
    if (wr_acc && hit(paddr, ADDR_OWN_ADDRESS) && !ser_en) begin
      own_addr <= pwdata[7:0];
    end
  end

  // Bus monitor: busy between a start and a stop from any master
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy  <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
    end
  end

  // Status flags set by the bus; match flags cleared by start or stop, arb_lost by a start request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_match <= 1'b0;
      gen_call   <= 1'b0;
      last_bit   <= 1'b0;
      arb_lost   <= 1'b0;
    end else begin
      if (byte_done && addr_phase && !mastering && addr_ok) begin
        addr_match <= 1'b1;
      end else if (start_det || stop_det) begin
        addr_match <= 1'b0;
      end
      if (byte_done && addr_phase && !mastering && gc_ok) begin
        gen_call <= 1'b1;
      end else if (start_det || stop_det) begin
        gen_call <= 1'b0;
      end
      if (scl_rise && engaged && bit_cnt == ACK_SLOT) begin
        last_bit <= sda_in;
      end
      if (arb_evt) begin
        arb_lost <= 1'b1;
      end else if (master_go) begin
        arb_lost <= 1'b0;
      end
    end
  end

  // Byte engine: bit count, address phase and slave selection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt    <= 4'h0;
      addr_phase <= 1'b0;
      slave_sel  <= 1'b0;
      first_fall <= 1'b0;
    end else if (!ser_en || stop_det) begin
      bit_cnt    <= 4'h0;
      addr_phase <= 1'b0;
      slave_sel  <= 1'b0;
      first_fall <= 1'b0;
    end else if (start_det) begin
      bit_cnt    <= 4'h0;
      addr_phase <= 1'b1;
      slave_sel  <= ~mastering;
      first_fall <= 1'b1;
    end else if (arb_evt) begin
      slave_sel  <= 1'b0;
    end else if (scl_fall && first_fall) begin
      first_fall <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt == ACK_SLOT) begin
        bit_cnt    <= 4'h0;
        addr_phase <= 1'b0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      // An unmatched slave drops out before the acknowledge slot
      if (bit_cnt == LAST_DATA_BIT && addr_phase && !mastering
          && !addr_ok && !gc_ok) begin
        slave_sel <= 1'b0;
      end
    end
  end

  // Shift register: software load while enabled, bus shifts on clock edges
  always_ff @(posedge clk_sys) begin
    if (wr_acc && hit(paddr, ADDR_SHIFT_DATA) && ser_en) begin
      shift_data <= pwdata[7:0];
    end else if (engaged && bit_cnt < ACK_SLOT) begin
      if (scl_rise && !tx_role) begin
        shift_data <= {shift_data[6:0], sda_in};
      end else if (bit_fall && tx_role && bit_cnt != LAST_DATA_BIT) begin
        shift_data <= {shift_data[6:0], 1'b0};
      end
    end
  end

  // Master clock generator: start, free bit clock, stop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cg_state   <= MMI2C_CG_IDLE;
      cg_scl_low <= 1'b0;
      cg_sda_low <= 1'b0;
    end else begin
      case (cg_state)
        MMI2C_CG_IDLE: begin
          cg_scl_low <= 1'b0;
          cg_sda_low <= 1'b0;
          if (master_go) begin
            cg_state <= MMI2C_CG_START;
          end
        end
        MMI2C_CG_START: begin
          if (!ser_en) begin
            cg_state <= MMI2C_CG_IDLE;
          end else if (half_tick) begin
            cg_sda_low <= 1'b1;
            cg_state   <= MMI2C_CG_SETUP;
          end
        end
        MMI2C_CG_SETUP: begin
          if (half_tick) begin
            cg_scl_low <= 1'b1;
            cg_state   <= MMI2C_CG_RUN;
          end
        end
        MMI2C_CG_RUN: begin
          if (arb_evt || !ser_en) begin
            cg_state <= MMI2C_CG_IDLE;
          end else if (cg_scl_low) begin
            if (half_tick && !hold) begin
              if (stop_req && bit_cnt == 4'h0) begin
                cg_sda_low <= 1'b1;
                cg_state   <= MMI2C_CG_STOP;
              end else begin
                cg_scl_low <= 1'b0;
              end
            end
          end else if (half_tick && scl_in) begin
            // High half only counts once a stretching slave lets go
            cg_scl_low <= 1'b1;
          end
        end
        MMI2C_CG_STOP: begin
          if (half_tick) begin
            if (cg_scl_low) begin
              cg_scl_low <= 1'b0;
            end else begin
              cg_sda_low <= 1'b0;
              cg_state   <= MMI2C_CG_IDLE;
            end
          end
        end
        default: begin
          cg_state <= MMI2C_CG_IDLE;
        end
      endcase
    end
  end

  // Data line from the engine: data bits when sending, acknowledge when receiving
  always_comb begin
    eng_sda_low = 1'b0;
    if (engaged) begin
      if (bit_cnt < ACK_SLOT) begin
        eng_sda_low = tx_role & ~shift_data[7];
      end else begin
        eng_sda_low = ~tx_role & ack_en;
      end
    end
  end

  always_comb begin
    next_scl_low = ser_en & ((cg_state != MMI2C_CG_IDLE & cg_scl_low)
                 | (engaged & hold));
    if (cg_state == MMI2C_CG_START || cg_state == MMI2C_CG_SETUP
        || cg_state == MMI2C_CG_STOP) begin
      next_sda_low = ser_en & cg_sda_low;
    end else begin
      next_sda_low = ser_en & eng_sda_low & ~arb_evt;
    end
  end

  // Open-drain pads: output level is always low, the enable does the work
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
    end else begin
      scl_oe_n <= ~next_scl_low;
      sda_oe_n <= ~next_sda_low;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
    end
  end

endmodule // mmi2c_ctrl
`default_nettype wire

// File: logic/mmi2c_pkg.sv
/*
  Constants for the multi-master two-wire serial bus control block:
  register byte addresses, field positions, reset values, mode codes and
  prescaler divide ratios.
  Assumes a 32-bit APB master and the block clocked at 250 MHz.
*/
// Overview of operation
// - Control bit 7 enables acknowledge, reset zero
// - Acknowledge slot: transmitter releases, receiver drives low
// - Control bit 6 selects clock divide 16 or 512
// - Control bit 5 enables transfer interrupt, reset zero
// - Pending flag holds serial clock low, stalls bus
// - Pending write one ignored, zero clears and resumes
// - Pending on byte done, address match, arbitration loss
// - Status bits 7:6 select mode, reset slave receive
// - Status bit 5 reads bus busy
// - Status bit 5 write one starts, zero stops
// - Status bit 4 enables serial operation, reset zero
// - Status bit 3 flags lost arbitration
// - Status bit 2 flags own address match
// - Status bit 1 flags general call address
// - Status bit 0 holds last received bit
// - Own address writable only while serial disabled
// - Own address in bits 7:1, bit 0 unmapped
// - Data register writable only while serial enabled
// - Clock held low until data written or read
`default_nettype none
package mmi2c_pkg;
  localparam logic [31:0] ADDR_BUS_CONTROL  = 32'h5400_0000;
  localparam logic [31:0] ADDR_CTRL_STATUS  = 32'h5400_0004;
  localparam logic [31:0] ADDR_OWN_ADDRESS  = 32'h5400_0008;
  localparam logic [31:0] ADDR_SHIFT_DATA   = 32'h5400_000C;

  localparam int BC_ACK_EN   = 7;
  localparam int BC_SRC_SEL  = 6;
  localparam int BC_INT_EN   = 5;
  localparam int BC_PENDING  = 4;
  localparam int ST_BUSY     = 5;
  localparam int ST_ENABLE   = 4;

  localparam logic [1:0] MODE_SLAVE_RX  = 2'h0;
  localparam logic [1:0] MODE_SLAVE_TX  = 2'h1;
  localparam logic [1:0] MODE_MASTER_RX = 2'h2;
  localparam logic [1:0] MODE_MASTER_TX = 2'h3;

  localparam logic [3:0] ACK_SLOT        = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT   = 4'h7;
  localparam logic [6:0] GENERAL_CALL    = 7'h00;

  localparam int          SRC_DIV_FAST  = 16;
  localparam int          SRC_DIV_SLOW  = 512;
  // Half ratios so the prescaler count marks half bit-clock periods
  localparam logic [7:0]  HALF_FAST_M1  = 8'(SRC_DIV_FAST / 2 - 1);
  localparam logic [7:0]  HALF_SLOW_M1  = 8'(SRC_DIV_SLOW / 2 - 1);

  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  typedef enum logic [2:0] {
    MMI2C_CG_IDLE,
    MMI2C_CG_START,
    MMI2C_CG_SETUP,
    MMI2C_CG_RUN,
    MMI2C_CG_STOP
  } mmi2c_cg_t;
endpackage : mmi2c_pkg
`default_nettype wire

// File: testbench/mmi2c_bus_model.sv
/* Far-side bus party: a slave that captures bytes and acknowledges on
   request, and a master with a byte task that opens with a start, and a stop task.
   Assumes the bench resolves both open-drain lines with pull-ups. */
`timescale 1ns/1ns
`default_nettype none
module mmi2c_bus_model #(
  parameter int HP = 40
) (
  input  wire logic       clk_sys,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_on,
  output var  logic       scl_oe_n,
  output var  logic       sda_oe_n,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_ack
);
  logic mst = 1'b0;
  int   cnt = 0;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    rx_byte  = 8'h00;
    rx_ack   = 1'b1;
  end
  always @(negedge sda) begin
    if (scl === 1'b1 && !mst) cnt <= 0;
  end
  always @(posedge scl) begin
    if (!mst && cnt >= 1 && cnt <= 8) rx_byte <= {rx_byte[6:0], sda};
  end
  // Slave acks only when told to, so the device's nack path is reachable
  always @(negedge scl) begin
    if (!mst) begin
      sda_oe_n <= !(cnt == 8 && ack_on);
      cnt      <= (cnt == 9) ? 1 : cnt + 1;
    end
  end
  task automatic half();
    repeat (HP) @(posedge clk_sys);
  endtask
  task automatic up();
    half();
    scl_oe_n <= 1'b1;
    @(posedge clk_sys);
    while (scl !== 1'b1) @(posedge clk_sys);
    rx_ack <= sda;
    half();
  endtask
  task automatic m_byte(input logic [7:0] b);
    logic [8:0] bits;
    bits = {b, 1'b1};
    mst = 1'b1;
    sda_oe_n <= 1'b0;
    half();
    scl_oe_n <= 1'b0;
    for (int i = 8; i >= 0; i--) begin
      half();
      sda_oe_n <= bits[i];
      up();
      scl_oe_n <= 1'b0;
    end
  endtask
  task automatic m_stop();
    half();
    sda_oe_n <= 1'b0;
    up();
    sda_oe_n <= 1'b1;
    half();
    mst = 1'b0;
  endtask
endmodule // mmi2c_bus_model
`default_nettype wire

// File: testbench/mmi2c_ctrl_assertions.sv
/* Checker for the two-wire control block: APB answer and clock hold.
   Assumes it is bound to the block's top module. */
`timescale 1ns/1ns
`default_nettype none
module mmi2c_ctrl_checker
  import mmi2c_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_oe_n,
  input wire logic        irq
);
  logic mapped;
  assign mapped = (paddr[31:4] == 28'h5400000) && (paddr[1:0] == 2'h0);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  err_decode_a: assert property (pready |-> (pslverr == !mapped))
    else $error("error flag disagrees with the address map");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  own_bit0_a: assert property (
    pready && !pwrite && paddr == ADDR_OWN_ADDRESS |-> prdata[0] == 1'b0)
    else $error("unmapped own address bit read as one");
  pend_hold_a: assert property (irq [*2] |-> !scl_oe_n)
    else $error("clock released while pending");
  irq_scl_a: assert property ($rose(irq) |-> ##[0:2] !scl_oe_n)
    else $error("pending raised without clock hold");
endmodule // mmi2c_ctrl_checker
bind mmi2c_ctrl mmi2c_ctrl_checker chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_oe_n(scl_oe_n), .irq(irq)
);
`default_nettype wire

// File: testbench/tb_multi_master_i2c_control_regs.sv
/* Self-checking bench for the two-wire control block: registers over
   APB, device as slave and as master against the bus model.
   Assumes open-drain lines with pull-ups, resolved here. */
`timescale 1ns/1ns
`default_nettype none
module tb_multi_master_i2c_control_regs;
  import mmi2c_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic        ack_on  = 1'b1;
  logic [31:0] prdata, r_data;
  logic [7:0]  rx_byte;
  logic        pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
  logic        m_scl_oe_n, m_sda_oe_n, rx_ack, r_err, scl, sda;
  int          fails = 0;
  int          total_checks = 0;
  assign scl = scl_oe_n & m_scl_oe_n;
  assign sda = sda_oe_n & m_sda_oe_n;
  always #2 clk_sys = ~clk_sys;
  mmi2c_ctrl uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq)
  );
  mmi2c_bus_model bus (
    .clk_sys(clk_sys), .scl(scl), .sda(sda), .ack_on(ack_on),
    .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n), .rx_byte(rx_byte),
    .rx_ack(rx_ack)
  );
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e,
                         input logic [31:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("MISMATCH at %0t got %h expected %h", $time, g & m, e & m);
    end
  endtask
  task automatic chk_num(input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, lo);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r_data  = prdata;
    r_err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk_reg(r_data, e, m);
  endtask
  task automatic wait_irq();
    @(posedge clk_sys);
    // A request cleared just before still shows for one cycle; let it fall first
    while (irq !== 1'b0) @(posedge clk_sys);
    while (irq !== 1'b1) @(posedge clk_sys);
  endtask
  task automatic wait_scl(input logic v);
    @(posedge clk_sys);
    while (scl !== v) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    rd(ADDR_BUS_CONTROL, 32'h0, 32'hF0);
    rd(ADDR_CTRL_STATUS, 32'h0, 32'hFF);
    wr(ADDR_BUS_CONTROL, 32'hF5);
    rd(ADDR_BUS_CONTROL, 32'hE5, 32'hFF);
    rd(32'h5400_0010, 32'h0, 32'hFFFFFFFF);
    chk_reg({31'h0, r_err}, 32'h1, 32'h1);
    $display("register test done");
  endtask
  task automatic t_own();
    wr(ADDR_OWN_ADDRESS, 32'hCD);
    rd(ADDR_OWN_ADDRESS, 32'hCC, 32'hFF);
    wr(ADDR_CTRL_STATUS, 32'h10);
    wr(ADDR_OWN_ADDRESS, 32'h5A);
    rd(ADDR_OWN_ADDRESS, 32'hCC, 32'hFF);
    wr(ADDR_SHIFT_DATA, 32'h3C);
    wr(ADDR_CTRL_STATUS, 32'h00);
    wr(ADDR_SHIFT_DATA, 32'hFF);
    rd(ADDR_SHIFT_DATA, 32'h3C, 32'hFF);
    wr(ADDR_CTRL_STATUS, 32'h10);
    rd(ADDR_CTRL_STATUS, 32'h10, 32'hFF);
    $display("own address test done");
  endtask
  task automatic t_slave(input logic [7:0] a, input logic [31:0] e);
    wr(ADDR_BUS_CONTROL, 32'hA2);
    bus.m_byte(a);
    chk_reg({31'h0, rx_ack}, 32'h0, 32'h1);
    wait_irq();
    rd(ADDR_CTRL_STATUS, e, 32'hFF);
    wr(ADDR_BUS_CONTROL, 32'hA2);
    rd(ADDR_SHIFT_DATA, {24'h0, a}, 32'hFF);
    bus.m_stop();
    rd(ADDR_CTRL_STATUS, 32'h10, 32'hFF);
    $display("slave test done");
  endtask
  task automatic t_master(input logic [31:0] c, input int h);
    int n;
    n = 0;
    ack_on <= 1'b1;
    wr(ADDR_BUS_CONTROL, c);
    wr(ADDR_SHIFT_DATA, 32'hA0);
    wr(ADDR_CTRL_STATUS, 32'hF0);
    wait_scl(1'b0);
    wait_scl(1'b1);
    while (scl === 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    while (scl === 1'b0) begin
      @(posedge clk_sys);
      n++;
    end
    // Slack of two cycles covers the sampled-line lag on the high half
    chk_num(n, 2 * h, 2 * h + 2);
    wait_irq();
    chk_reg({24'h0, rx_byte}, 32'hA0, 32'hFF);
    rd(ADDR_CTRL_STATUS, 32'hF0, 32'hFF);
    repeat (100) @(posedge clk_sys);
    chk_reg({31'h0, scl}, 32'h0, 32'h1);
    chk_reg({29'h0, scl_out, scl_oe_n, sda_out}, 32'h0, 32'h7);
    ack_on <= 1'b0;
    wr(ADDR_SHIFT_DATA, 32'h96);
    wr(ADDR_BUS_CONTROL, c);
    wait_irq();
    chk_reg({24'h0, rx_byte}, 32'h96, 32'hFF);
    rd(ADDR_CTRL_STATUS, 32'hF1, 32'hFF);
    wr(ADDR_CTRL_STATUS, 32'hD0);
    wr(ADDR_BUS_CONTROL, c);
    apb(1'b0, ADDR_SHIFT_DATA, 32'h0);
    r_data = 32'h20;
    while (r_data[5] === 1'b1) apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk_reg(r_data, 32'h0, 32'h20);
    $display("master test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_own();
    t_slave(8'hCC, 32'h34);
    t_slave(8'h00, 32'h32);
    t_master(32'hA2, 24);
    t_master(32'hE0, 256);
    tally_and_finish();
  end
  // Longest run is the divide-by-512 transfer, near 10k cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end
endmodule // tb_multi_master_i2c_control_regs
`default_nettype wire
